// ### term_seq_pkg.sv
/*
 package for the dynamic termination sequencer: register offsets, field
 positions, reset values, state encoding and the carrier structs.
 assumes a 32-bit ahb-lite slave with word registers.
*/
package term_seq_pkg;

   localparam int CODE_W = 14;

   // register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] SCODE_OFF  = 8'h08;
   localparam logic [7:0] PCODE_OFF  = 8'h0C;
   localparam logic [7:0] CALCNT_OFF = 8'h10;

   // control fields
   localparam int CTRL_DRIVE_BIT  = 0;
   localparam int CTRL_OUTONLY_BIT = 1;
   localparam int CTRL_HALF_BIT   = 2;
   localparam int CTRL_FREEZE_BIT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_OE_BIT    = 4;
   localparam int STAT_DT_BIT    = 5;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   typedef enum logic [1:0] {
      ST_RECEIVE  = 2'b00,
      ST_TERM_OFF = 2'b01,
      ST_DRIVE    = 2'b10,
      ST_OE_OFF   = 2'b11
   } seq_state_t;

   typedef struct packed {
      logic [CODE_W-1:0] series_code;
      logic [CODE_W-1:0] parallel_code;
   } code_pair_t;

   typedef struct packed {
      logic oe;
      logic dyn_term;
   } pin_ctrl_t;

endpackage : term_seq_pkg

// ### term_seq.sv
/*
 dynamic termination sequencer: orders output enable and dynamic parallel
 termination select of bidirectional pins and fans the calibration codes
 of one calibration block out to every pin, over an ahb-lite register port.
 assumes one calibration block per bank feeding cal_codes, all pins of one
 instance share termination values and bank supply.
*/
`timescale 1ns/1ps

// Operation
// - receive: output enable low, termination select high, parallel term on.
// - drive: output enable high, termination select low, parallel term off.
// - each pin gets a 14-bit series and parallel code from one block.
// - output-only pins get the series code on both code buses.
// - one block may feed many pins sharing termination and supply.
// - at most one calibration block supplies a given bank.
// - 25-ohm drive from 50-ohm reference by halving the code.
// - no multiplying 25-ohm reference up to 50 ohm.
// - user-mode recalibration refreshes the delivered codes any time; the code takes no new codes while the freeze bit is set.
module term_seq #(
   parameter int NPINS = 1
) (
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic      [31:0]                hrdata,
   output logic                            hreadyout,
   output logic                            hresp,
   input  wire logic [NPINS-1:0]           drive_req,
   input  wire term_seq_pkg::code_pair_t   cal_codes,
   input  wire logic                       cal_valid,
   output term_seq_pkg::pin_ctrl_t [NPINS-1:0] pin_ctrl,
   output term_seq_pkg::code_pair_t        series_code_bus,
   output term_seq_pkg::code_pair_t        parallel_code_bus
);
   import term_seq_pkg::*;

   typedef struct packed {
      seq_state_t [NPINS-1:0] st;
      pin_ctrl_t  [NPINS-1:0] pc;
      logic [3:0]             ctrl;
      code_pair_t             codes;
      logic [15:0]            cal_cnt;
      logic                   wr_pend;
      logic [7:0]             addr;
      logic [31:0]            rdata;
   } state_t;

   state_t s_reg;
   state_t s_next;

   function automatic logic [CODE_W-1:0] halve(input logic [CODE_W-1:0] c);
      halve = {1'b0, c[CODE_W-1:1]};
   endfunction : halve

   function automatic logic [31:0] read_mux(input state_t s);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (s.addr)
         CTRL_OFF:   r[3:0] = s.ctrl;
         STATUS_OFF: begin
            r[STAT_STATE_LSB +: 2] = s.st[0];
            r[STAT_OE_BIT]         = s.pc[0].oe;
            r[STAT_DT_BIT]         = s.pc[0].dyn_term;
         end
         SCODE_OFF:  r[CODE_W-1:0] = s.codes.series_code;
         PCODE_OFF:  r[CODE_W-1:0] = s.codes.parallel_code;
         CALCNT_OFF: r[15:0] = s.cal_cnt;
         default:    r = 32'h0000_0000;
      endcase
      read_mux = r;
   endfunction : read_mux

   always_comb begin
      logic take;
      logic want;
      take = 1'b0;
      want = 1'b0;
      s_next = s_reg;
      // bus data phase: write lands, read data registered
      if (s_reg.wr_pend && s_reg.addr == CTRL_OFF) begin
         s_next.ctrl = hwdata[3:0];
      end
      s_next.wr_pend = 1'b0;
      take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
      if (take) begin
         s_next.addr    = haddr[7:0];
         s_next.wr_pend = hwrite;
         s_next.addr[1:0] = 2'h0;
      end
      if (take && !hwrite) begin
         s_next.rdata = read_mux(s_next);
      end
      // one shared calibration source for every pin of this bank
      if (cal_valid && !s_reg.ctrl[CTRL_FREEZE_BIT]) begin
         s_next.codes   = cal_codes;
         s_next.cal_cnt = s_reg.cal_cnt + 16'h0001;
      end
      // per-pin ordering of enable and termination select
      for (int i = 0; i < NPINS; i++) begin
         want = drive_req[i] | s_reg.ctrl[CTRL_DRIVE_BIT];
         case (s_reg.st[i])
            ST_RECEIVE: begin
               s_next.pc[i] = '{oe: 1'b0, dyn_term: 1'b1};
               if (want) begin
                  s_next.st[i] = ST_TERM_OFF;
                  s_next.pc[i].dyn_term = 1'b0;
               end
            end
            ST_TERM_OFF: begin
               if (want) begin
                  s_next.st[i] = ST_DRIVE;
                  s_next.pc[i] = '{oe: 1'b1, dyn_term: 1'b0};
               end else begin
                  s_next.st[i] = ST_RECEIVE;
                  s_next.pc[i] = '{oe: 1'b0, dyn_term: 1'b1};
               end
            end
            ST_DRIVE: begin
               if (!want) begin
                  s_next.st[i] = ST_OE_OFF;
                  s_next.pc[i].oe = 1'b0;
               end
            end
            ST_OE_OFF: begin
               if (want) begin
                  s_next.st[i] = ST_TERM_OFF;
               end else begin
                  s_next.st[i] = ST_RECEIVE;
                  s_next.pc[i] = '{oe: 1'b0, dyn_term: 1'b1};
               end
            end
            default: begin
               s_next.st[i] = ST_RECEIVE;
               s_next.pc[i] = '{oe: 1'b0, dyn_term: 1'b1};
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NPINS; i++) begin
            s_reg.st[i] <= ST_RECEIVE;
            s_reg.pc[i] <= '{oe: 1'b0, dyn_term: 1'b1};
         end
         s_reg.ctrl    <= CTRL_RESET;
         s_reg.codes   <= '0;
         s_reg.cal_cnt <= 16'h0000;
         s_reg.wr_pend <= 1'b0;
         s_reg.addr    <= 8'h00;
         s_reg.rdata   <= 32'h0000_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pin_ctrl  = s_reg.pc;
   assign hrdata    = s_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // series bus carries full and halved series code for 50/25-ohm drive; with the half bit set both fields carry the halved code
   always_comb begin
      series_code_bus.series_code   = s_reg.codes.series_code;
      series_code_bus.parallel_code = halve(s_reg.codes.series_code);
      // output-only pins take the series code in both registers
      if (s_reg.ctrl[CTRL_OUTONLY_BIT]) begin
         parallel_code_bus.series_code   = s_reg.codes.series_code;
         parallel_code_bus.parallel_code = s_reg.codes.series_code;
      end else begin
         parallel_code_bus.series_code   = s_reg.codes.parallel_code;
         parallel_code_bus.parallel_code = s_reg.codes.parallel_code;
      end
      // half drive only ever divides a 50-ohm code, never multiplies
      if (s_reg.ctrl[CTRL_HALF_BIT]) begin
         series_code_bus.series_code = halve(s_reg.codes.series_code);
      end
   end

endmodule : term_seq

// ### core_model.sv
/*
 model of the user core logic that asks a pin to drive or receive.
 assumes the sequencer clock; toggles at random spacing while run is high.
*/
`timescale 1ns/1ps
module core_model (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic run,
   input  wire logic want,
   output logic      drive_req
);
   int unsigned hold = 0;
   initial drive_req = 1'b0;
   // request is a register of the core clock domain
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_req <= 1'b0;
      end else if (!run) begin
         drive_req <= want;
      end else if (hold != 0) begin
         hold <= hold - 1;
      end else begin
         drive_req <= !drive_req;
         hold      <= $urandom_range(0, 6);
      end
   end
endmodule : core_model

// ### term_seq_checker.sv
/*
 port checker for term_seq.
 assumes it is bound to every term_seq instance.
*/
`timescale 1ns/1ps
module term_seq_checker import term_seq_pkg::*; #(parameter int NPINS = 1) (
   input wire logic                       clk,
   input wire logic                       reset_n,
   input wire logic                       hsel,
   input wire logic [31:0]                haddr,
   input wire logic [1:0]                 htrans,
   input wire logic                       hwrite,
   input wire logic [31:0]                hwdata,
   input wire logic                       hready,
   input wire logic [31:0]                hrdata,
   input wire logic                       hreadyout,
   input wire logic                       hresp,
   input wire logic [NPINS-1:0]           drive_req,
   input wire pin_ctrl_t [NPINS-1:0]      pin_ctrl,
   input wire code_pair_t                 series_code_bus,
   input wire code_pair_t                 parallel_code_bus
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic ctrl_wr_pend;
   logic force_drive;
   // shadow of the force-drive control bit, taken from the bus traffic
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_wr_pend <= 1'b0;
         force_drive  <= 1'b0;
      end else begin
         ctrl_wr_pend <= hsel && hready && hwrite &&
            htrans == HTRANS_NONSEQ && haddr[7:2] == CTRL_OFF[7:2];
         if (ctrl_wr_pend) begin
            force_drive <= hwdata[CTRL_DRIVE_BIT];
         end
      end
   end
   oe_excl_a: assert property (pin_ctrl[0].oe |-> !pin_ctrl[0].dyn_term)
      else $error("oe with termination on");
   term_first_a: assert property ($rose(pin_ctrl[0].oe) |->
      !$past(pin_ctrl[0].dyn_term)) else $error("oe rose too early");
   term_late_a: assert property ($rose(pin_ctrl[0].dyn_term) |->
      !$past(pin_ctrl[0].oe)) else $error("termination rose too early");
   term_drop_a: assert property (drive_req[0] && pin_ctrl[0].dyn_term
      |=> !pin_ctrl[0].dyn_term) else $error("termination not dropped");
   oe_rise_a: assert property (drive_req[0] && pin_ctrl[0].dyn_term
      ##1 drive_req[0] |=> pin_ctrl[0].oe) else $error("oe late");
   oe_drop_a: assert property (!drive_req[0] && !force_drive &&
      pin_ctrl[0].oe |=> !pin_ctrl[0].oe) else $error("oe not dropped");
   bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stall");
   unmapped_zero_a: assert property (hsel && hready && !hwrite &&
      htrans == HTRANS_NONSEQ && haddr == 32'h14 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   code_same_a: assert property (parallel_code_bus.series_code ==
      parallel_code_bus.parallel_code) else $error("code halves differ");
   half_code_a: assert property ((series_code_bus.parallel_code ==
      series_code_bus.series_code >> 1) || (series_code_bus.parallel_code
      == series_code_bus.series_code)) else $error("halved code wrong");
endmodule : term_seq_checker
bind term_seq term_seq_checker #(.NPINS(NPINS)) chk (.clk(clk),
   .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .drive_req(drive_req),
   .pin_ctrl(pin_ctrl), .series_code_bus(series_code_bus),
   .parallel_code_bus(parallel_code_bus));

// ### tb.sv
/*
 testbench for term_seq: bus master, calibration source, core model.
 assumes term_seq_pkg, core_model and the checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
   import term_seq_pkg::*;
   logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, cal_valid = 0;
   logic run = 0, want = 0, rd_dp = 0, hreadyout, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q[$];
   logic [1:0] htrans = '0;
   logic [0:0] drive_req;
   code_pair_t cal_codes = '0, sb, pb, c;
   pin_ctrl_t [0:0] pin_ctrl;
   int n_mismatch = 0, checks_done = 0, cyc = 0, i;
   always #2 clk = ~clk;
   term_seq #(.NPINS(1)) dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .drive_req(drive_req),
      .cal_codes(cal_codes), .cal_valid(cal_valid), .pin_ctrl(pin_ctrl),
      .series_code_bus(sb), .parallel_code_bus(pb));
   core_model core (.clk(clk), .reset_n(reset_n), .run(run), .want(want),
      .drive_req(drive_req[0]));
   task chk(input logic ok);
      checks_done++;
      if (!ok) begin
         n_mismatch++;
         $display("BAD %0t compare failed", $time);
      end
   endtask : chk
   task test_done;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task ahb(input logic w, input logic [31:0] a, d);
      @(posedge clk);
      hsel <= 1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= d; rd_dp <= !w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd_dp <= 0;
   endtask : ahb
   task rd(input logic [31:0] a, e);
      q.push_back(e);
      ahb(0, a, 32'h0);
   endtask : rd
   task load(input code_pair_t v);
      @(posedge clk); cal_codes <= v; cal_valid <= 1;
      @(posedge clk); cal_valid <= 0;
      repeat (2) @(posedge clk);
      #1;
   endtask : load
   always @(posedge clk) if (rd_dp && hreadyout) chk(hrdata === q.pop_front());
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin n_mismatch++; test_done; end
   end
   initial begin
      i = $urandom(32'h10e9);
      repeat (3) @(posedge clk);
      reset_n <= 1;
      rd(CTRL_OFF, 32'h0);
      rd(STATUS_OFF, 32'h20);
      rd(CALCNT_OFF, 32'h0);
      for (i = 0; i < 4; i++) begin
         c = 28'($urandom);
         ahb(1, CTRL_OFF, 32'(i << 1));
         load(c);
         chk(pb === (i[0] ? {2{c.series_code}} : {2{c.parallel_code}}));
         chk(sb.series_code === (i[1] ? c.series_code >> 1 : c.series_code));
         rd(SCODE_OFF, 32'(c.series_code));
         rd(PCODE_OFF, 32'(c.parallel_code));
      end
      rd(CALCNT_OFF, 32'h4);
      ahb(1, CTRL_OFF, 32'hE);
      load(~c);
      chk(pb === {2{c.series_code}});
      ahb(1, 32'h14, 32'hFFFF_FFFF);
      rd(32'h14, 32'h0);
      ahb(1, CTRL_OFF, 32'h0);
      run <= 1; repeat (300) @(posedge clk);
      run <= 0; want <= 1; repeat (6) @(posedge clk);
      rd(STATUS_OFF, 32'h12);
      want <= 0; repeat (6) @(posedge clk);
      rd(STATUS_OFF, 32'h20);
      ahb(1, CTRL_OFF, 32'h1);
      repeat (6) @(posedge clk);
      rd(STATUS_OFF, 32'h12);
      ahb(1, CTRL_OFF, 32'h0);
      repeat (6) @(posedge clk);
      rd(STATUS_OFF, 32'h20);
      want <= 1;
      repeat (6) @(posedge clk);
      reset_n <= 0;
      want <= 0;
      repeat (3) @(posedge clk);
      reset_n <= 1;
      rd(STATUS_OFF, 32'h20);
      rd(CALCNT_OFF, 32'h0);
      test_done;
   end
endmodule : tb
